/* File: inc/sps_defines.svh */
// register offsets, field positions, reset values and masks of the soft-pin section
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

// register indices; byte address is four times the index
`define SPS_IDX_FREQ_SEL  14'h0C01
`define SPS_IDX_ENABLE    14'h0C03
`define SPS_IDX_REF_SCALE 14'h0C04
`define SPS_IDX_CH_SCALE  14'h0C05
`define SPS_IDX_LOOP      14'h0C06
`define SPS_IDX_START     14'h0C07
`define SPS_IDX_SPRESET   14'h0C08

// writable bits of each register, reserved bits clear
`define SPS_MASK_FREQ_SEL 8'hFF
`define SPS_MASK_ENABLE   8'h01
`define SPS_MASK_SCALE    8'h0F
`define SPS_MASK_LOOP     8'h1F
`define SPS_MASK_GO       8'h01

// reset value of every register
`define SPS_RST_VAL       8'h00

// field positions
`define SPS_EN_BIT        0
`define SPS_GO_BIT        0
`define SPS_HIGH_PM_BIT   4
`define SPS_LO_FIELD      1:0
`define SPS_HI_FIELD      3:2
`define SPS_IN_SEL_FIELD  3:0
`define SPS_OUT_SEL_FIELD 7:4

// scale factors and defaults
`define SPS_DIV_1         5'h01
`define SPS_DIV_4         5'h04
`define SPS_DIV_8         5'h08
`define SPS_DIV_16        5'h10
`define SPS_LOOP_BW_DFLT  2'h0
`define SPS_TOL_DFLT      2'h0

`endif

/* File: inc/sps_pkg.sv */
// types of the soft-pin section two configuration bank
package sps_pkg;

  // settings handed to the translation loader
  typedef struct packed {
    logic [3:0] in_sel;
    logic [3:0] out_sel;
    logic [4:0] ref_first_div;
    logic [4:0] ref_second_div;
    logic [4:0] ch0_div;
    logic [4:0] ch1_div;
    logic       high_pm;
    logic [1:0] loop_bw;
    logic [1:0] freq_tol;
  } sps_applied_s;

  // download sequencer
  typedef enum logic [0:0] {
    SPS_IDLE,
    SPS_LOAD
  } sps_state_e;

endpackage : sps_pkg

/* File: hdl/sps_config.sv */
// soft-pin section two configuration registers with Avalon-MM slave
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.svh"

// Behaviour
// R1: section two honoured when enable is 1 and pin-program select pin low.
// R2: enable resets to 0; while 0 section two scaling is ignored.
// R3: second reference scale, bits 3:2, codes give divide 1, 4, 8, 16.
// R4: first reference scale, bits 1:0, codes give divide 1, 4, 8, 16.
// R5: channel one output scale, bits 3:2, divide 1, 4, 8, 16.
// R6: channel zero output scale, bits 1:0, divide 1, 4, 8, 16.
// R7: loop bit 4 picks 70 or 88.5 degree phase margin filter.
// R8: loop bits 3:2 set loop bandwidth, code 00 is 50 Hz.
// R9: scales apply to the preset input and output selections.
// R10: settings take effect only on start transfer or soft-pin reset.
// R11: start bit begins download and clears itself when download completes.
// R12: input selection picks one of sixteen presets, profiles reloaded.
// R13: reserved bits read zero and writes to them are ignored.
module sps_config (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic [15:0]          address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [3:0]           byteenable,
  input  wire logic [31:0]          writedata,
  output logic      [31:0]          readdata,
  output logic                      waitrequest,
  input  wire logic                 pin_program_select_pin,
  output logic                      rom_load_start,
  input  wire logic                 rom_load_done,
  output logic                      rom_load_busy,
  output sps_pkg::sps_applied_s     applied
);

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------

  // scale code to divide ratio
  function automatic logic [4:0] scale_div(input logic [1:0] code);
    logic [4:0] d;
    d = `SPS_DIV_1;
    unique case (code)
      2'h0: d = `SPS_DIV_1;
      2'h1: d = `SPS_DIV_4;
      2'h2: d = `SPS_DIV_8;
      2'h3: d = `SPS_DIV_16;
    endcase
    return d;
  endfunction : scale_div

  // -------------------------------------------------------------
  // bus slave
  // -------------------------------------------------------------

  logic        ack_reg;
  logic        ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [13:0] idx;
  logic        aligned;
  logic        wr_go;
  logic [7:0]  wbyte;

  assign idx     = address[15:2];
  assign aligned = (address[1:0] == 2'h0);
  // one wait cycle, then the answer
  assign waitrequest = (read | write) & ~ack_reg;
  assign wr_go       = write & ack_reg & byteenable[0] & aligned;
  assign wbyte       = writedata[7:0];
  assign readdata    = rdata_reg;

  logic [7:0] sel_reg, sel_next;
  logic [7:0] en_reg, en_next;
  logic [7:0] ref_reg, ref_next;
  logic [7:0] ch_reg, ch_next;
  logic [7:0] loop_reg, loop_next;
  logic [7:0] start_reg, start_next;
  logic [7:0] sprst_reg, sprst_next;

  sps_pkg::sps_state_e state_reg, state_next;
  sps_pkg::sps_applied_s applied_reg, applied_next;
  logic load_go;
  logic load_done;
  logic honour;
  logic start_pulse_reg;

  // answer and read data
  always_comb begin
    ack_next   = (read | write) & ~ack_reg;
    rdata_next = rdata_reg;
    if ((read | write) & ~ack_reg) begin
      rdata_next = 32'h0000_0000;
      if (aligned) begin
        // R13 reserved read zero
        unique case (idx)
          `SPS_IDX_FREQ_SEL:  rdata_next[7:0] = sel_reg;
          `SPS_IDX_ENABLE:    rdata_next[7:0] = en_reg;
          `SPS_IDX_REF_SCALE: rdata_next[7:0] = ref_reg;
          `SPS_IDX_CH_SCALE:  rdata_next[7:0] = ch_reg;
          `SPS_IDX_LOOP:      rdata_next[7:0] = loop_reg;
          `SPS_IDX_START:     rdata_next[7:0] = start_reg;
          `SPS_IDX_SPRESET:   rdata_next[7:0] = sprst_reg;
          default:            rdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // -------------------------------------------------------------
  // configuration registers
  // -------------------------------------------------------------

  assign load_done = (state_reg == sps_pkg::SPS_LOAD) & rom_load_done;

  // software writes; hardware clears go bits at download end
  always_comb begin
    sel_next   = sel_reg;
    en_next    = en_reg;
    ref_next   = ref_reg;
    ch_next    = ch_reg;
    loop_next  = loop_reg;
    start_next = start_reg;
    sprst_next = sprst_reg;
    // R11 self clearing start
    if (load_done) begin
      start_next = `SPS_RST_VAL;
      sprst_next = `SPS_RST_VAL;
    end
    // R13 reserved writes dropped
    if (wr_go) begin
      unique case (idx)
        `SPS_IDX_FREQ_SEL:  sel_next  = wbyte & `SPS_MASK_FREQ_SEL;
        `SPS_IDX_ENABLE:    en_next   = wbyte & `SPS_MASK_ENABLE;
        `SPS_IDX_REF_SCALE: ref_next  = wbyte & `SPS_MASK_SCALE;
        `SPS_IDX_CH_SCALE:  ch_next   = wbyte & `SPS_MASK_SCALE;
        `SPS_IDX_LOOP:      loop_next = wbyte & `SPS_MASK_LOOP;
        // set wins over the hardware clear
        `SPS_IDX_START: begin
          if (wbyte[`SPS_GO_BIT]) start_next = `SPS_MASK_GO;
        end
        `SPS_IDX_SPRESET: begin
          if (wbyte[`SPS_GO_BIT]) sprst_next = `SPS_MASK_GO;
        end
        default: ;
      endcase
    end
  end

  // R2 enable resets clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_reg   <= `SPS_RST_VAL;
      en_reg    <= `SPS_RST_VAL;
      ref_reg   <= `SPS_RST_VAL;
      ch_reg    <= `SPS_RST_VAL;
      loop_reg  <= `SPS_RST_VAL;
      start_reg <= `SPS_RST_VAL;
      sprst_reg <= `SPS_RST_VAL;
    end else begin
      sel_reg   <= sel_next;
      en_reg    <= en_next;
      ref_reg   <= ref_next;
      ch_reg    <= ch_next;
      loop_reg  <= loop_next;
      start_reg <= start_next;
      sprst_reg <= sprst_next;
    end
  end

  // -------------------------------------------------------------
  // download sequencer and applied settings
  // -------------------------------------------------------------

  // R1 soft pins honoured
  assign honour  = en_reg[`SPS_EN_BIT] & ~pin_program_select_pin;
  assign load_go = (state_reg == sps_pkg::SPS_IDLE) &
                   (start_reg[`SPS_GO_BIT] | sprst_reg[`SPS_GO_BIT]);

  // snapshot settings when a download begins
  always_comb begin
    state_next   = state_reg;
    applied_next = applied_reg;
    unique case (state_reg)
      sps_pkg::SPS_IDLE: begin
        // R10 apply on trigger
        if (load_go) begin
          state_next = sps_pkg::SPS_LOAD;
          // R9 scales follow presets
          // R12 preset input selection
          applied_next.in_sel  = sel_reg[`SPS_IN_SEL_FIELD];
          applied_next.out_sel = sel_reg[`SPS_OUT_SEL_FIELD];
          // R2 defaults when disabled
          applied_next.ref_first_div  = `SPS_DIV_1;
          applied_next.ref_second_div = `SPS_DIV_1;
          applied_next.ch0_div        = `SPS_DIV_1;
          applied_next.ch1_div        = `SPS_DIV_1;
          applied_next.high_pm        = 1'b0;
          applied_next.loop_bw        = `SPS_LOOP_BW_DFLT;
          applied_next.freq_tol       = `SPS_TOL_DFLT;
          if (honour) begin
            // R3 second reference scale
            applied_next.ref_second_div = scale_div(ref_reg[`SPS_HI_FIELD]);
            // R4 first reference scale
            applied_next.ref_first_div  = scale_div(ref_reg[`SPS_LO_FIELD]);
            // R5 channel one scale
            applied_next.ch1_div        = scale_div(ch_reg[`SPS_HI_FIELD]);
            // R6 channel zero scale
            applied_next.ch0_div        = scale_div(ch_reg[`SPS_LO_FIELD]);
            // R7 phase margin select
            applied_next.high_pm        = loop_reg[`SPS_HIGH_PM_BIT];
            // R8 loop bandwidth code
            applied_next.loop_bw        = loop_reg[`SPS_HI_FIELD];
            applied_next.freq_tol       = loop_reg[`SPS_LO_FIELD];
          end
        end
      end
      sps_pkg::SPS_LOAD: begin
        if (rom_load_done) begin
          state_next = sps_pkg::SPS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= sps_pkg::SPS_IDLE;
      applied_reg <= '{in_sel: 4'h0, out_sel: 4'h0,
                       ref_first_div: `SPS_DIV_1, ref_second_div: `SPS_DIV_1,
                       ch0_div: `SPS_DIV_1, ch1_div: `SPS_DIV_1,
                       high_pm: 1'b0, loop_bw: `SPS_LOOP_BW_DFLT,
                       freq_tol: `SPS_TOL_DFLT};
      start_pulse_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      applied_reg <= applied_next;
      start_pulse_reg <= load_go;
    end
  end

  // loader outputs
  assign rom_load_start = start_pulse_reg;
  assign rom_load_busy  = (state_reg == sps_pkg::SPS_LOAD);
  assign applied        = applied_reg;

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_bus_one_wait: assert property ( // local design decision, one wait cycle
    (read | write) && !ack_reg |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait cycle");

  a_reserved_read_zero: assert property ( // R13
    read && !waitrequest |-> readdata[31:8] == 24'h0 &&
      (idx == `SPS_IDX_FREQ_SEL || readdata[7:5] == 3'h0))
    else $error("reserved read bits not zero");

  a_apply_only_trigger: assert property ( // R10
    !load_go |=> $stable(applied))
    else $error("settings changed without a trigger");

  a_disabled_defaults: assert property ( // R2
    load_go && !honour |=> applied.ref_first_div == 5'h01 &&
      applied.ch1_div == 5'h01 && !applied.high_pm && applied.loop_bw == 2'h0)
    else $error("disabled section not at defaults");

  a_ref_second_copy: assert property ( // R3
    load_go && honour && ref_reg[3:2] == 2'h3 |=> applied.ref_second_div == 5'h10)
    else $error("second reference scale wrong");

  a_ref_first_copy: assert property ( // R4
    load_go && honour && ref_reg[1:0] == 2'h1 |=> applied.ref_first_div == 5'h04)
    else $error("first reference scale wrong");

  a_ch_scale_copy: assert property ( // R5
    load_go && honour && ch_reg[3:2] == 2'h2 |=> applied.ch1_div == 5'h08)
    else $error("channel one scale wrong");

  a_ch0_scale_copy: assert property ( // R6
    load_go && honour |=> applied.ch0_div ==
      (5'h01 << (($past(ch_reg[1:0]) == 2'h0) ? 0 : $past(ch_reg[1:0]) + 1)))
    else $error("channel zero scale wrong");

  a_loop_copy: assert property ( // R7
    load_go && honour |=> applied.high_pm == $past(loop_reg[4]) &&
      applied.loop_bw == $past(loop_reg[3:2]))
    else $error("loop settings not taken");

  a_sel_copy: assert property ( // R9
    load_go |=> applied.in_sel == $past(sel_reg[3:0]) &&
      applied.out_sel == $past(sel_reg[7:4]))
    else $error("preset selection not taken");

  a_start_autoclear: assert property ( // R11
    load_done && !wr_go |=> start_reg == 8'h00 ##0 !rom_load_busy)
    else $error("start bit not cleared at download end");

  a_start_pulse: assert property ( // R10
    load_go |=> rom_load_start && rom_load_busy ##1 !rom_load_start)
    else $error("download start not a single pulse");

  c_enabled_load: cover property (load_go && honour ##[1:20] load_done);
  c_disabled_load: cover property (load_go && !honour);
  c_set_wins: cover property (load_done && wr_go && idx == `SPS_IDX_START);

endmodule : sps_config

`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench of the soft-pin section two configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                  clk;
  logic                  reset_n;
  logic [15:0]           address;
  logic                  read;
  logic                  write;
  logic [3:0]            byteenable;
  logic [31:0]           writedata;
  logic [31:0]           readdata;
  logic                  waitrequest;
  logic                  pin_program_select_pin;
  logic                  rom_load_start;
  logic                  rom_load_done;
  logic                  rom_load_busy;
  sps_pkg::sps_applied_s applied;
  sps_pkg::sps_applied_s rst_app;
  logic [39:0]           rd_q[$];
  logic [39:0]           ap_q[$];
  int                    failures;
  int                    cmp_count;
  logic [7:0]            fs, en, rs, cs, lp;

  sps_config u_sps_config (.clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .pin_program_select_pin(pin_program_select_pin), .rom_load_start(rom_load_start),
    .rom_load_done(rom_load_done), .rom_load_busy(rom_load_busy), .applied(applied));

  // clock of 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // compare and count
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // one avalon access; for a read d is the expected byte
  task automatic bus(input logic wr, input logic [13:0] idx, input logic [7:0] d);
    if (!wr) rd_q.push_back({32'h0000_0000, d});
    address    <= {idx, 2'h0};
    writedata  <= {8'($urandom_range(0, 255)), 16'h0000, d};
    byteenable <= 4'hF;
    read       <= !wr;
    write      <= wr;
    // hold until waitrequest is seen low; only the watchdog ends a hang
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus

  function automatic logic [4:0] dv(input logic [1:0] c);
    case (c)
      2'h0: return 5'h01;
      2'h1: return 5'h04;
      2'h2: return 5'h08;
      default: return 5'h10;
    endcase
  endfunction : dv

  // expected settings at a load trigger
  function automatic sps_pkg::sps_applied_s exp_app(input logic pin);
    sps_pkg::sps_applied_s a;
    logic on;
    on = en[0] && !pin;
    a.in_sel = fs[3:0];
    a.out_sel = fs[7:4];
    a.ref_first_div = on ? dv(rs[1:0]) : 5'h01;
    a.ref_second_div = on ? dv(rs[3:2]) : 5'h01;
    a.ch0_div = on ? dv(cs[1:0]) : 5'h01;
    a.ch1_div = on ? dv(cs[3:2]) : 5'h01;
    a.high_pm = on & lp[4];
    a.loop_bw = on ? lp[3:2] : 2'h0;
    a.freq_tol = on ? lp[1:0] : 2'h0;
    return a;
  endfunction : exp_app

  // trigger a download, finish it after a random delay
  task automatic load(input logic [13:0] go);
    bus(1'b1, go, 8'h01);
    while (rom_load_busy !== 1'b1) @(posedge clk);
    bus(1'b0, go, 8'h01);
    repeat ($urandom_range(1, 6)) @(posedge clk);
    rom_load_done <= 1'b1;
    @(posedge clk);
    rom_load_done <= 1'b0;
    @(posedge clk);
    check(rom_load_busy, 0);
    bus(1'b0, go, 8'h00);
  endtask : load

  // result watcher: read data and applied settings
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0 && rd_q.size() > 0) check(readdata, rd_q.pop_front());
    if (rom_load_start === 1'b1) begin
      if (ap_q.size() > 0) check(applied, ap_q.pop_front());
      else check(1, 0);
    end
  end

  // watchdog
  initial begin
    #2_000_000;
    failures++;
    final_report();
  end

  // main sequence
  initial begin
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 16'h0000;
    byteenable = 4'h0;
    writedata = 32'h0000_0000;
    pin_program_select_pin = 1'b0;
    rom_load_done = 1'b0;
    failures = 0;
    cmp_count = 0;
    void'($urandom(15928));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rst_app = '0;
    {rst_app.ref_first_div, rst_app.ref_second_div} = {5'h01, 5'h01};
    {rst_app.ch0_div, rst_app.ch1_div} = {5'h01, 5'h01};
    check(applied, rst_app);
    // reset values, unmapped places included
    for (int i = 1; i <= 9; i++) bus(1'b0, 14'h0C00 + 14'(i), 8'h00);
    // readback through reserved bits
    for (int i = 0; i < 4; i++) begin
      {fs, en, rs, cs, lp} = 40'({$urandom, $urandom});
      bus(1'b1, 14'h0C01, fs);
      bus(1'b1, 14'h0C03, en);
      bus(1'b1, 14'h0C04, rs);
      bus(1'b1, 14'h0C05, cs);
      bus(1'b1, 14'h0C06, lp);
      bus(1'b1, 14'h0C02, 8'hFF);
      bus(1'b0, 14'h0C01, fs);
      bus(1'b0, 14'h0C03, en & 8'h01);
      bus(1'b0, 14'h0C04, rs & 8'h0F);
      bus(1'b0, 14'h0C05, cs & 8'h0F);
      bus(1'b0, 14'h0C06, lp & 8'h1F);
      bus(1'b0, 14'h0C02, 8'h00);
    end
    // writes alone change nothing
    check(applied, rst_app);
    // every scale code, with enable off in one pass and pin high in another
    for (int k = 0; k < 16; k++) begin
      {fs, lp} = {8'($urandom_range(0, 255)), 8'($urandom_range(0, 255))};
      en = {7'($urandom_range(0, 127)), 1'(k != 5)};
      rs = {4'($urandom_range(0, 15)), 4'(k)};
      cs = {4'($urandom_range(0, 15)), 4'(15 - k)};
      pin_program_select_pin <= (k == 9);
      bus(1'b1, 14'h0C01, fs);
      bus(1'b1, 14'h0C03, en);
      bus(1'b1, 14'h0C04, rs);
      bus(1'b1, 14'h0C05, cs);
      bus(1'b1, 14'h0C06, lp);
      ap_q.push_back(exp_app(k == 9));
      load(k[0] ? 14'h0C08 : 14'h0C07);
    end
    check(ap_q.size(), 0);
    check(rd_q.size(), 0);
    final_report();
  end
endmodule : tb
`default_nettype wire
